//--- rtl/arc_pkg.sv
// strap-driven negotiation setup, reset sequencing and expansion status
// constants, field positions, timing counts and carrier types.
// assumes a 50 MHz core clock and a decoded management access port.
//
// Overview of operation
// - high strap low, low strap mid: no negotiation, 10 Mb/s half duplex
// - high strap high, low strap mid: no negotiation, 10 Mb/s full duplex
// - high strap mid, low strap low: no negotiation, 100 Mb/s half duplex
// - high strap mid, low strap high: no negotiation, 100 Mb/s full duplex
// - both straps mid: negotiate, advertise all four abilities
// - both straps low: negotiate, advertise 10 Mb/s half duplex only
// - high low, low high: negotiate, advertise 10 Mb/s full duplex only
// - high high, low low: negotiate, advertise 100 Mb/s half duplex only
// - both straps high: negotiate, advertise 100 Mb/s full duplex only
// - each negotiation strap decodes to low, mid or high
// - several links seen in parallel detection set multiple link fault
// - expansion reports partner next page, page received, partner ability
// - local next page ability always reads zero
// - both receivers' link status feeds negotiation for parallel detection
// - valid 100 Mb/s idles from a plain partner settle on 100 Mb/s
// - reset on reset pin, power-up, or software reset bit
// - all straps captured within 2 us of reset release
// - latch station address, negotiation and mode straps at reset
// - during power-up reset the low-speed indicator is asserted
// - software writes to basic control override the strapped mode
// - software reset restores defaults, no re-latch, bit self-clears

package arc_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int STRAP_LATCH_MAX_NS = 2000;
  localparam int STRAP_LATCH_CYC = STRAP_LATCH_MAX_NS / CLK_PERIOD_NS;
  // latch halfway into the window so straps have settled after release
  localparam logic [7:0] STRAP_SETTLE_CYC = 8'(STRAP_LATCH_CYC / 2);
  localparam logic [7:0] SOFT_RST_CYC = 8'h04;

  // ==========================================================
  // register offsets and fields
  localparam logic [4:0] ADDR_BASIC_CTRL = 5'h00;
  localparam logic [4:0] ADDR_ADVERT = 5'h04;
  localparam logic [4:0] ADDR_EXPANSION = 5'h06;
  localparam int BC_RESET_BIT = 15;
  localparam int BC_LOOP_BIT = 14;
  localparam int BC_SPEED_BIT = 13;
  localparam int BC_ANEN_BIT = 12;
  localparam int BC_RESTART_BIT = 9;
  localparam int BC_DUPLEX_BIT = 8;
  localparam int ADV_LSB = 5;
  localparam int EXP_NP_BIT = 2;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;
  localparam logic [3:0] ADV_ALL = 4'hf;

  // ==========================================================
  // types
  typedef enum logic [1:0] {TRI_LOW, TRI_MID, TRI_HIGH} arc_tri_t;

  typedef struct packed {
    logic a;
    logic b;
  } arc_tri_pin_t;

  typedef struct packed {
    arc_tri_pin_t negotiation_strap_high;
    arc_tri_pin_t negotiation_strap_low;
    logic [4:0] station_addr_strap;
    logic repeater_strap;
    logic serial_10m_strap;
    logic align_bypass_strap;
    logic block_code_bypass_strap;
    logic scrambler_bypass_strap;
  } arc_strap_pins_t;

  typedef struct packed {
    arc_tri_t neg_high;
    arc_tri_t neg_low;
    logic [4:0] station_addr;
    logic repeater;
    logic serial_10m;
    logic align_bypass;
    logic block_code_bypass;
    logic scrambler_bypass;
  } arc_strap_cfg_t;

endpackage : arc_pkg

//--- rtl/arc_strap_config.sv
// strap latch, reset sequencer, basic control / advertisement /
// expansion registers and parallel-detect resolution.
// assumes management accesses arrive already decoded on the core clock;
// strap pins and the reset pin are asynchronous to the core clock.
`timescale 1ns/1ns

module arc_strap_config
  import arc_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic HW_RESET,
  input wire arc_strap_pins_t STRAP_PINS,
  input wire logic LINK10_OK,
  input wire logic LINK100_OK,
  input wire logic PARTNER_AN_ABLE,
  input wire logic PARTNER_NEXT_PAGE,
  input wire logic [3:0] PARTNER_ABILITY,
  input wire logic PAGE_RECEIVED,
  input wire logic [4:0] MGMT_ADDR,
  input wire logic MGMT_WR,
  input wire logic MGMT_RD,
  input wire logic [15:0] MGMT_WDATA,
  output logic [15:0] MGMT_RDATA,
  output arc_strap_cfg_t STRAP_CFG,
  output logic CFG_VALID,
  output logic AN_ENABLE,
  output logic [3:0] ADVERT_ABILITY,
  output logic SPEED_100,
  output logic FULL_DUPLEX,
  output logic LINK_UP,
  output logic [4:0] STATUS_LAMP_OUTPUTS_N,
  output logic SPEED_10_IND
);

  localparam int LATCH_BOUND = STRAP_LATCH_CYC;

  typedef enum logic [1:0] {ST_RESET, ST_SETTLE, ST_RUN, ST_SOFT} arc_st_t;

  // ==========================================================
  // helpers
  // tri-level pin: two comparators, LL low, LH mid, HH high
  function automatic arc_tri_t tri_decode(input arc_tri_pin_t p);
    tri_decode = TRI_MID; // HL cannot occur, take the safe middle
    if (!p.a && !p.b) tri_decode = TRI_LOW;
    else if (p.a && p.b) tri_decode = TRI_HIGH;
  endfunction : tri_decode

  // defaults {an_en, speed, duplex, advert[3:0]} selected by the straps
  function automatic logic [6:0] strap_dflt(input arc_tri_t hi,
                                            input arc_tri_t lo);
    strap_dflt = {1'b1, 1'b1, 1'b1, ADV_ALL};
    case ({hi, lo})
      {TRI_LOW, TRI_MID}: strap_dflt = {3'b000, ADV_ALL};
      {TRI_HIGH, TRI_MID}: strap_dflt = {3'b001, ADV_ALL};
      {TRI_MID, TRI_LOW}: strap_dflt = {3'b010, ADV_ALL};
      {TRI_MID, TRI_HIGH}: strap_dflt = {3'b011, ADV_ALL};
      {TRI_LOW, TRI_LOW}: strap_dflt = {3'b111, 4'h1};
      {TRI_LOW, TRI_HIGH}: strap_dflt = {3'b111, 4'h2};
      {TRI_HIGH, TRI_LOW}: strap_dflt = {3'b111, 4'h4};
      {TRI_HIGH, TRI_HIGH}: strap_dflt = {3'b111, 4'h8};
      default: strap_dflt = {1'b1, 1'b1, 1'b1, ADV_ALL};
    endcase
  endfunction : strap_dflt

  // ==========================================================
  // synchronisers for the reset pin and the straps
  logic hw_s1_r, hw_s2_r;
  arc_strap_pins_t strap_s1_r, strap_s2_r;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      hw_s1_r <= 1'b1; // pin taken as asserted until seen low
      hw_s2_r <= 1'b1;
      strap_s1_r <= '0;
      strap_s2_r <= '0;
    end else begin
      hw_s1_r <= HW_RESET;
      hw_s2_r <= hw_s1_r;
      strap_s1_r <= STRAP_PINS;
      strap_s2_r <= strap_s1_r;
    end
  end

  // ==========================================================
  // reset sequencer
  arc_st_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic pwr_r;
  logic wr_ok, wr_bc, wr_adv, rd_exp, soft_req, latch_now, soft_done;
  logic load_dflt;

  assign wr_ok = MGMT_WR && (state_r == ST_RUN) && !hw_s2_r;
  assign wr_bc = wr_ok && (MGMT_ADDR == ADDR_BASIC_CTRL);
  assign wr_adv = wr_ok && (MGMT_ADDR == ADDR_ADVERT);
  assign rd_exp = MGMT_RD && (MGMT_ADDR == ADDR_EXPANSION);
  assign soft_req = wr_bc && MGMT_WDATA[BC_RESET_BIT];
  assign latch_now = (state_r == ST_SETTLE) && !hw_s2_r &&
                     (cnt_r == STRAP_SETTLE_CYC - 8'h01);
  assign soft_done = (state_r == ST_SOFT) && !hw_s2_r &&
                     (cnt_r == SOFT_RST_CYC - 8'h01);
  assign load_dflt = latch_now || soft_done;

  // the pin reset always wins; software reset only from normal running
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 8'h01;
    case (state_r)
      ST_RESET: begin
        cnt_nxt = 8'h00;
        if (!hw_s2_r) state_nxt = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (latch_now) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        cnt_nxt = 8'h00;
        if (soft_req) state_nxt = ST_SOFT;
      end
      ST_SOFT: begin
        if (soft_done) state_nxt = ST_RUN;
      end
      default: state_nxt = ST_RESET;
    endcase
    if (hw_s2_r) begin
      state_nxt = ST_RESET;
      cnt_nxt = 8'h00;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      state_r <= ST_RESET;
      cnt_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // power-up flag: set by the core reset, cleared once straps are taken
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) pwr_r <= 1'b1;
    else if (latch_now) pwr_r <= 1'b0;
  end

  // ==========================================================
  // strap latch, held until the next hardware or power-up reset
  arc_strap_cfg_t cfg_r, cfg_new, dflt_src;
  logic cfg_valid_r;
  logic [6:0] dflt;

  assign cfg_new = '{neg_high: tri_decode(strap_s2_r.negotiation_strap_high),
                     neg_low: tri_decode(strap_s2_r.negotiation_strap_low),
                     station_addr: strap_s2_r.station_addr_strap,
                     repeater: strap_s2_r.repeater_strap,
                     serial_10m: strap_s2_r.serial_10m_strap,
                     align_bypass: strap_s2_r.align_bypass_strap,
                     block_code_bypass: strap_s2_r.block_code_bypass_strap,
                     scrambler_bypass: strap_s2_r.scrambler_bypass_strap};
  // software reset reuses the held straps instead of sampling pins
  assign dflt_src = latch_now ? cfg_new : cfg_r;
  assign dflt = strap_dflt(dflt_src.neg_high, dflt_src.neg_low);

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      cfg_r <= '{neg_high: TRI_MID, neg_low: TRI_MID, default: '0};
      cfg_valid_r <= 1'b0;
    end else if (latch_now) begin
      cfg_r <= cfg_new;
      cfg_valid_r <= 1'b1;
    end else if (state_r == ST_RESET) begin
      cfg_valid_r <= 1'b0;
    end
  end

  // ==========================================================
  // basic control and advertisement; shows the live mode and a software
  // write in normal running without the reset bit overrides what the straps selected
  logic sreset_r, loop_r, speed_r, an_en_r, restart_r, duplex_r;
  logic [3:0] adv_r;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || state_r == ST_RESET) begin
      sreset_r <= 1'b0;
      loop_r <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      sreset_r <= soft_req || (sreset_r && !soft_done);
      loop_r <= load_dflt ? 1'b0 : (wr_bc ? MGMT_WDATA[BC_LOOP_BIT] : loop_r);
      restart_r <= wr_bc && MGMT_WDATA[BC_RESTART_BIT];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      {an_en_r, speed_r, duplex_r} <= 3'b111;
      adv_r <= ADV_ALL;
    end else if (load_dflt) begin
      {an_en_r, speed_r, duplex_r} <= dflt[6:4];
      adv_r <= dflt[3:0];
    end else begin
      if (wr_bc && !MGMT_WDATA[BC_RESET_BIT]) begin
        an_en_r <= MGMT_WDATA[BC_ANEN_BIT];
        speed_r <= MGMT_WDATA[BC_SPEED_BIT];
        duplex_r <= MGMT_WDATA[BC_DUPLEX_BIT];
      end
      if (wr_adv) adv_r <= MGMT_WDATA[ADV_LSB +: 4];
    end
  end

  // ==========================================================
  // expansion status: sticky flags clear on read, a new event wins
  logic mlf_r, page_r, mlf_set;

  assign mlf_set = (state_r == ST_RUN) && an_en_r && !PARTNER_AN_ABLE &&
                   LINK10_OK && LINK100_OK;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || load_dflt || state_r == ST_RESET) begin
      mlf_r <= 1'b0;
      page_r <= 1'b0;
    end else begin
      mlf_r <= mlf_set || (mlf_r && !rd_exp);
      page_r <= PAGE_RECEIVED || (page_r && !rd_exp);
    end
  end

  // ==========================================================
  // read data; unmapped offsets read zero
  logic [15:0] bc_word, adv_word, exp_word, rd_mux;

  assign bc_word = {sreset_r, loop_r, speed_r, an_en_r, 2'b00, restart_r,
                    duplex_r, 8'h00};
  assign adv_word = {7'h00, adv_r, ADV_SELECTOR};
  // local next page ability is a hard zero
  assign exp_word = {11'h000, mlf_r, PARTNER_NEXT_PAGE, 1'b0, page_r,
                     PARTNER_AN_ABLE};
  assign rd_mux = (MGMT_ADDR == ADDR_BASIC_CTRL) ? bc_word :
                  (MGMT_ADDR == ADDR_ADVERT) ? adv_word :
                  (MGMT_ADDR == ADDR_EXPANSION) ? exp_word : 16'h0000;

  // ==========================================================
  // mode resolution: forced, negotiated by priority, or parallel detect
  logic [3:0] common;
  logic res_spd, res_dup, res_link;

  assign common = adv_r & PARTNER_ABILITY;

  always_comb begin
    res_spd = speed_r;
    res_dup = duplex_r;
    res_link = speed_r ? LINK100_OK : LINK10_OK;
    if (an_en_r && PARTNER_AN_ABLE) begin
      res_spd = common[3] || common[2];
      res_dup = common[3] || (!common[2] && common[1]);
      res_link = (|common) && (res_spd ? LINK100_OK : LINK10_OK);
    end else if (an_en_r) begin
      // a plain partner is half duplex; two links at once is a fault
      res_spd = LINK100_OK;
      res_dup = 1'b0;
      res_link = LINK100_OK ^ LINK10_OK;
    end
  end

  // ==========================================================
  // output flops; lamps held dark in pin and power-up reset, not in software reset; low-speed shown in power-up reset and at 10 Mb/s
  logic in_rst;
  assign in_rst = (state_r == ST_RESET) || (state_r == ST_SETTLE);

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      MGMT_RDATA <= 16'h0000;
      SPEED_100 <= 1'b0;
      FULL_DUPLEX <= 1'b0;
      LINK_UP <= 1'b0;
      STATUS_LAMP_OUTPUTS_N <= 5'h1f;
      SPEED_10_IND <= 1'b1;
    end else begin
      if (MGMT_RD) MGMT_RDATA <= rd_mux;
      SPEED_100 <= !in_rst && res_spd;
      FULL_DUPLEX <= !in_rst && res_dup;
      LINK_UP <= !in_rst && res_link;
      STATUS_LAMP_OUTPUTS_N <= in_rst ? 5'h1f :
        ~{res_link, res_spd, res_dup, an_en_r, mlf_r};
      SPEED_10_IND <= (in_rst && pwr_r) || (!in_rst && !res_spd);
    end
  end

  assign STRAP_CFG = cfg_r;
  assign CFG_VALID = cfg_valid_r;
  assign AN_ENABLE = an_en_r;
  assign ADVERT_ABILITY = adv_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  chk_forced_10_half: assert property (
    latch_now && cfg_new.neg_high == TRI_LOW && cfg_new.neg_low == TRI_MID
    |=> !an_en_r && !speed_r && !duplex_r && adv_r == 4'hf)
    else $error("forced 10 half defaults wrong");
  chk_forced_100_full: assert property (
    latch_now && cfg_new.neg_high == TRI_MID && cfg_new.neg_low == TRI_HIGH
    |=> !an_en_r && speed_r && duplex_r)
    else $error("forced 100 full defaults wrong");
  chk_adv_all_mid: assert property (
    latch_now && cfg_new.neg_high == TRI_MID && cfg_new.neg_low == TRI_MID
    |=> an_en_r && adv_r == 4'hf)
    else $error("all-ability advertisement wrong");
  chk_adv_10_half: assert property (
    latch_now && cfg_new.neg_high == TRI_LOW && cfg_new.neg_low == TRI_LOW
    |=> an_en_r && adv_r == 4'h1)
    else $error("10 half advertisement wrong");
  chk_adv_100_full: assert property (
    latch_now && cfg_new.neg_high == TRI_HIGH && cfg_new.neg_low == TRI_HIGH
    |=> an_en_r && adv_r == 4'h8)
    else $error("100 full advertisement wrong");
  chk_mlf_sets: assert property (
    !hw_s2_r && mlf_set |=> mlf_r ##1 (mlf_r || $past(rd_exp)))
    else $error("multiple link fault not held");
  chk_np_reads_zero: assert property (
    MGMT_RD && MGMT_ADDR == ADDR_EXPANSION |=> !MGMT_RDATA[EXP_NP_BIT])
    else $error("local next page ability not zero");
  chk_pd_settles_100: assert property (
    state_r == ST_RUN && !hw_s2_r && an_en_r && !PARTNER_AN_ABLE &&
    LINK100_OK && !LINK10_OK |=> SPEED_100 && LINK_UP && !FULL_DUPLEX)
    else $error("parallel detect missed 100 Mb/s");
  chk_pin_resets: assert property (
    hw_s2_r |=> state_r == ST_RESET ##1 !cfg_valid_r)
    else $error("reset pin did not reset");
  chk_latch_in_time: assert property (
    state_r == ST_RESET && !hw_s2_r
    |-> ##[1:LATCH_BOUND] (cfg_valid_r || hw_s2_r))
    else $error("straps not latched in time");
  chk_soft_keeps_straps: assert property (
    soft_req |=> (sreset_r && $stable(cfg_r)) [*4] ##1 !sreset_r)
    else $error("software reset re-latched or stuck");
  chk_lowspeed_in_rst: assert property (
    in_rst && pwr_r |=> SPEED_10_IND && STATUS_LAMP_OUTPUTS_N == 5'h1f)
    else $error("low-speed indicator not asserted");

endmodule : arc_strap_config

//--- bench/arc_far_end.sv
// far-side model: board reset circuit, strap wiring and a link partner.
// assumes the bench raises pulse_req for one cycle to ask for a reset pulse.
`timescale 1ns/1ns

module arc_far_end
  import arc_pkg::*;
#(
  parameter int PULSE_CYC = 50,
  parameter int PWRUP_CYC = 25000 // 500 us of 20 ns cycles
)(
  input wire logic clk,
  input wire logic pulse_req,
  input wire arc_tri_t strap_hi,
  input wire arc_tri_t strap_lo,
  input wire logic [9:0] misc_straps,
  input wire logic [1:0] link_kind,
  output arc_strap_pins_t strap_pins,
  output logic hw_reset,
  output logic link10,
  output logic link100
);
  logic [7:0] cnt_r = 8'h00;
  logic [14:0] por_cnt_r = 15'h0000;
  logic por_hold;

  // ==========================================================
  // tri-level wiring: ground 00, open 01, supply 11
  function automatic arc_tri_pin_t wire_tri(input arc_tri_t t);
    return (t == TRI_LOW) ? 2'b00 : (t == TRI_MID) ? 2'b01 : 2'b11;
  endfunction : wire_tri

  assign strap_pins = {wire_tri(strap_hi), wire_tri(strap_lo), misc_straps};

  // ==========================================================
  // board reset circuit: pin held from power-up for 500 us, later
  // pulses of at least 1 us, never inside that first hold
  assign por_hold = (por_cnt_r != 15'(PWRUP_CYC));

  always_ff @(posedge clk) begin
    if (por_hold) begin
      por_cnt_r <= por_cnt_r + 15'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (pulse_req && !por_hold) begin
      cnt_r <= 8'(PULSE_CYC);
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign hw_reset = por_hold || (cnt_r != 8'h00);

  // link partner: a plain partner only shows receiver link, one cycle late
  always_ff @(posedge clk) begin
    link10 <= link_kind[0];
    link100 <= link_kind[1];
  end
endmodule : arc_far_end

//--- bench/testbench.sv
// self-checking bench for the strap loader and expansion status.
// assumes the far-side model drives straps, reset pin and receiver links.
`timescale 1ns/1ns

module testbench;
  import arc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pulse_req = 1'b0;
  arc_tri_t s_hi = TRI_MID;
  arc_tri_t s_lo = TRI_MID;
  logic [9:0] misc = 10'h000;
  logic [1:0] link_kind = 2'h0;
  logic an_able = 1'b0;
  logic np = 1'b0;
  logic [3:0] abl = 4'h0;
  logic page = 1'b0;
  logic [4:0] m_addr = 5'h00;
  logic m_wr = 1'b0;
  logic m_rd = 1'b0;
  logic [15:0] m_wdata = 16'h0000;
  logic [15:0] m_rdata;
  arc_strap_pins_t pins;
  arc_strap_cfg_t cfg;
  logic hw_reset, link10, link100, cfg_valid, an_en, spd, fdx, link_up;
  logic [3:0] adv;
  logic [4:0] lamps_n;
  logic spd10;
  int bad_count = 0;
  int checked = 0;
  int seed = 38;

  initial begin
    forever #10 clk = ~clk;
  end

  arc_far_end far (.clk(clk), .pulse_req(pulse_req), .strap_hi(s_hi),
    .strap_lo(s_lo), .misc_straps(misc), .link_kind(link_kind),
    .strap_pins(pins), .hw_reset(hw_reset), .link10(link10),
    .link100(link100));

  arc_strap_config dut (.CORE_CLK(clk), .RESET_N(rst_n),
    .HW_RESET(hw_reset), .STRAP_PINS(pins), .LINK10_OK(link10),
    .LINK100_OK(link100), .PARTNER_AN_ABLE(an_able),
    .PARTNER_NEXT_PAGE(np), .PARTNER_ABILITY(abl), .PAGE_RECEIVED(page),
    .MGMT_ADDR(m_addr), .MGMT_WR(m_wr), .MGMT_RD(m_rd),
    .MGMT_WDATA(m_wdata), .MGMT_RDATA(m_rdata), .STRAP_CFG(cfg),
    .CFG_VALID(cfg_valid), .AN_ENABLE(an_en), .ADVERT_ABILITY(adv),
    .SPEED_100(spd), .FULL_DUPLEX(fdx), .LINK_UP(link_up),
    .STATUS_LAMP_OUTPUTS_N(lamps_n), .SPEED_10_IND(spd10));

  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    m_addr <= a;
    m_rd <= 1'b1;
    @(posedge clk);
    m_rd <= 1'b0;
    #1 d = m_rdata;
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    m_addr <= a;
    m_wdata <= d;
    m_wr <= 1'b1;
    @(posedge clk);
    m_wr <= 1'b0;
  endtask : wr

  // {an, speed, duplex, advert[8:5]} selected by the strap pair
  function automatic logic [6:0] exp_mode(input int h, input int l);
    case (h * 3 + l)
      0: return 7'h41;
      1: return 7'h0f;
      2: return 7'h42;
      3: return 7'h2f;
      4: return 7'h7f;
      5: return 7'h3f;
      6: return 7'h44;
      7: return 7'h1f;
      default: return 7'h48;
    endcase
  endfunction : exp_mode

  // highest common ability, local side advertising everything
  function automatic logic [1:0] exp_res(input logic [3:0] a);
    if (a[3]) return 2'b11;
    if (a[2]) return 2'b10;
    if (a[1]) return 2'b01;
    return 2'b00;
  endfunction : exp_res

  // wait out the reset pin, then time the strap capture after release
  task automatic wait_capture;
    int n;
    n = 0;
    while (hw_reset === 1'b1 && n < 30000) begin
      tick(1);
      n++;
    end
    n = 0;
    while (cfg_valid !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk(16'(n <= STRAP_LATCH_CYC), 16'h1, "strap capture late");
  endtask : wait_capture

  // pulse the reset pin and time the strap capture after its release
  task automatic do_reset(input arc_tri_t h, input arc_tri_t l);
    @(posedge clk);
    s_hi <= h;
    s_lo <= l;
    misc <= 10'($random(seed));
    pulse_req <= 1'b1;
    @(posedge clk);
    pulse_req <= 1'b0;
    tick(2);
    wait_capture();
  endtask : do_reset

  task automatic stop_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] d;
    logic [6:0] e;
    logic [9:0] held;
    tick(5);
    chk(16'({spd10, lamps_n}), 16'h3f, "outputs in reset");
    @(posedge clk);
    rst_n <= 1'b1;
    tick(20);
    chk(16'({cfg_valid, spd10}), 16'h1, "power-up hold");
    wait_capture();
    chk(16'(cfg_valid), 16'h1, "power-up capture");
    $display("test power-up done");
    // every strap pair, with random mode straps
    for (int i = 0; i < 9; i++) begin
      do_reset(arc_tri_t'(i / 3), arc_tri_t'(i % 3));
      e = exp_mode(i / 3, i % 3);
      held = misc;
      chk(16'(an_en), 16'(e[6]), "an enable");
      chk(16'(adv), 16'(e[3:0]), "advert port");
      rd(ADDR_BASIC_CTRL, d);
      chk(16'({d[12], d[13] & ~e[6], d[8] & ~e[6]}),
          16'({e[6], e[5:4] & {2{~e[6]}}}), "ctrl");
      rd(ADDR_ADVERT, d);
      chk(16'(d[8:5]), 16'(e[3:0]), "advert reg");
      chk(16'(cfg[9:0]), 16'(held), "mode straps");
      @(posedge clk);
      misc <= ~held;
      tick(10);
      chk(16'(cfg[9:0]), 16'(held), "straps held");
    end
    $display("test strap modes done");
    // parallel detection with a plain partner
    do_reset(TRI_MID, TRI_MID);
    link_kind <= 2'h2;
    tick(6);
    chk(16'({link_up, spd, fdx, spd10}), 16'hc, "100 idles");
    chk(16'(lamps_n), 16'h05, "lamps on 100 link");
    link_kind <= 2'h1;
    tick(6);
    chk(16'({link_up, spd, fdx, spd10}), 16'h9, "10 link");
    link_kind <= 2'h3;
    tick(6);
    chk(16'({link_up, lamps_n[0]}), 16'h0, "no link on fault");
    rd(ADDR_EXPANSION, d);
    chk(16'({d[4], d[2]}), 16'h2, "multi link");
    link_kind <= 2'h0;
    $display("test parallel detect done");
    // negotiating partner, random abilities
    @(posedge clk);
    an_able <= 1'b1;
    np <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      abl <= 4'($random(seed)) | 4'h1;
      @(posedge clk);
      page <= 1'b1;
      @(posedge clk);
      page <= 1'b0;
      tick(4);
      chk(16'({spd, fdx}), 16'(exp_res(abl)), "resolve");
      rd(ADDR_EXPANSION, d);
      chk(16'(d[3:0]), 16'hb, "expansion");
    end
    wr(ADDR_EXPANSION, 16'hffff);
    rd(ADDR_EXPANSION, d);
    chk(16'(d[2]), 16'h0, "np ability");
    $display("test expansion done");
    // software override, then software reset without re-latch
    @(posedge clk);
    an_able <= 1'b0;
    wr(ADDR_BASIC_CTRL, 16'h2100);
    tick(4);
    chk(16'({an_en, spd, fdx}), 16'h3, "override");
    @(posedge clk);
    s_lo <= TRI_LOW;
    wr(ADDR_BASIC_CTRL, 16'h8000);
    rd(ADDR_BASIC_CTRL, d);
    chk(16'(d[15]), 16'h1, "sreset busy");
    tick(10);
    rd(ADDR_BASIC_CTRL, d);
    chk(16'({d[15], d[12]}), 16'h1, "sreset done");
    chk(16'(cfg.neg_low), 16'(TRI_MID), "no relatch");
    $display("test software reset done");
    stop_test();
  end

  // ==========================================================
  // watchdog, far beyond the expected run of about 26,400 cycles,
  // most of it the 500 us power-up hold of the reset pin
  initial begin
    #1200000;
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end
endmodule : testbench
